//--- core/mra_arbiter.sv
// Fixed-priority request arbiter and clock output of the memory interface
`timescale 1ns/100ps
`include "mra_defines.svh"
module mra_arbiter #(
  parameter int NUM_REQ = `MRA_NUM_REQ,
  parameter int ADDR_W  = `MRA_ADDR_W
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      pll_rst_done_i,
  input  wire logic [NUM_REQ-1:0]        req_i,
  input  wire logic [NUM_REQ*ADDR_W-1:0] req_addr_i,
  input  wire logic                      refresh_due_i,
  input  wire logic                      refresh_done_i,
  input  wire logic                      svc_done_i,
  output logic [NUM_REQ-1:0]             grant_o,
  output logic                           fwd_valid_o,
  output logic [ADDR_W-1:0]              fwd_addr_o,
  output mra_pkg::mra_target_t           fwd_target_o,
  output logic [`MRA_SRC_W-1:0]          fwd_src_o,
  output logic                           refresh_req_o,
  output logic                           mem_clk_o
);
  // The clock on mclk_i is the PLL system domain; no other source
  // is selectable, so no external clock can reach the core

  mra_pkg::mra_state_t  state;
  mra_pkg::mra_state_t  next_state;
  logic [NUM_REQ-1:0]   next_grant;
  logic                 next_fwd_valid;
  logic [ADDR_W-1:0]    next_fwd_addr;
  mra_pkg::mra_target_t next_fwd_target;
  logic [`MRA_SRC_W-1:0] next_fwd_src;
  logic                 next_refresh_req;
  logic                 next_mem_clk;
  logic                 pll_ready;
  logic                 clk_run;
  logic                 next_clk_run;
  logic [NUM_REQ-1:0]   win_onehot;
  logic [`MRA_SRC_W-1:0] win_idx;
  logic                 win_any;
  logic [ADDR_W-1:0]    win_addr;

  mra_sync u_pll_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .async_i (pll_rst_done_i),
    .sync_o  (pll_ready)
  );

  function automatic mra_pkg::mra_target_t decode_target(
    input logic [ADDR_W-1:0] addr
  );
    logic [`MRA_REGION_W-1:0] region;
    region = addr[ADDR_W-1 -: `MRA_REGION_W];
    if (region == `MRA_REGION_SDRAM) begin
      decode_target = mra_pkg::MRA_TGT_SDRAM;
    end else if (region == `MRA_REGION_ASYNC) begin
      decode_target = mra_pkg::MRA_TGT_ASYNC;
    end else begin
      decode_target = mra_pkg::MRA_TGT_CFG;
    end
  endfunction : decode_target

  // Lowest index is highest rank; scanning downward lets it win
  always_comb begin
    win_onehot = `MRA_NONE;
    win_idx    = `MRA_SRC_RST;
    win_any    = 1'b0;
    win_addr   = `MRA_ADDR_RST;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        win_onehot    = `MRA_NONE;
        win_onehot[i] = 1'b1;
        win_idx       = `MRA_SRC_W'(i);
        win_any       = 1'b1;
        win_addr      = req_addr_i[i*ADDR_W +: ADDR_W];
      end
    end
  end

  // State group: arbitration happens only in IDLE, so every
  // completion re-examines the whole pending set
  always_comb begin
    next_state = state;
    unique case (state)
      mra_pkg::MRA_IDLE: begin
        if (win_any && refresh_due_i) begin
          next_state = mra_pkg::MRA_REFRESH;
        end else if (win_any) begin
          next_state = mra_pkg::MRA_SERVE;
        end
      end
      mra_pkg::MRA_REFRESH: begin
        // Refresh ahead of the held request; latency is not fixed
        if (refresh_done_i) begin
          next_state = mra_pkg::MRA_SERVE;
        end
      end
      mra_pkg::MRA_SERVE: begin
        // No new grant and no preemption until the core finishes
        if (svc_done_i) begin
          next_state = mra_pkg::MRA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= mra_pkg::MRA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Grant group: address, target and source are captured with the
  // grant and held, so the core sees one stable request throughout
  always_comb begin
    next_grant      = grant_o;
    next_fwd_valid  = fwd_valid_o;
    next_fwd_addr   = fwd_addr_o;
    next_fwd_target = fwd_target_o;
    next_fwd_src    = fwd_src_o;
    unique case (state)
      mra_pkg::MRA_IDLE: begin
        if (win_any) begin
          next_grant      = win_onehot;
          next_fwd_addr   = win_addr;
          next_fwd_target = decode_target(win_addr);
          next_fwd_src    = win_idx;
          next_fwd_valid  = !refresh_due_i;
        end
      end
      mra_pkg::MRA_REFRESH: begin
        if (refresh_done_i) begin
          next_fwd_valid = 1'b1;
        end
      end
      mra_pkg::MRA_SERVE: begin
        // Grant drops with completion, never on a newcomer
        if (svc_done_i) begin
          next_fwd_valid = 1'b0;
          next_grant     = `MRA_NONE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      grant_o      <= `MRA_NONE;
      fwd_valid_o  <= 1'b0;
      fwd_addr_o   <= `MRA_ADDR_RST;
      fwd_target_o <= mra_pkg::MRA_TGT_SDRAM;
      fwd_src_o    <= `MRA_SRC_RST;
    end else begin
      grant_o      <= next_grant;
      fwd_valid_o  <= next_fwd_valid;
      fwd_addr_o   <= next_fwd_addr;
      fwd_target_o <= next_fwd_target;
      fwd_src_o    <= next_fwd_src;
    end
  end

  // Refresh group: the refresh is asked for only before a service
  // starts, never in the middle of one
  always_comb begin
    next_refresh_req = refresh_req_o;
    unique case (state)
      mra_pkg::MRA_IDLE: begin
        if (win_any && refresh_due_i) begin
          next_refresh_req = 1'b1;
        end
      end
      mra_pkg::MRA_REFRESH: begin
        if (refresh_done_i) begin
          next_refresh_req = 1'b0;
        end
      end
      mra_pkg::MRA_SERVE: begin
        next_refresh_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refresh_req_o <= 1'b0;
    end else begin
      refresh_req_o <= next_refresh_req;
    end
  end

  // Run flag: set once the synchronised PLL release is seen and kept
  // until reset, so the memory clock never stops mid-transfer
  always_comb begin
    next_clk_run = clk_run | pll_ready;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_run <= 1'b0;
    end else begin
      clk_run <= next_clk_run;
    end
  end

  // Memory clock is a toggle flop, so the pin runs at half mclk_i;
  // a flop output avoids gating the clock net itself
  always_comb begin
    next_mem_clk = clk_run ? ~mem_clk_o : 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_clk_o <= 1'b0;
    end else begin
      mem_clk_o <= next_mem_clk;
    end
  end
endmodule : mra_arbiter

//--- core/mra_defines.svh
// Constants for the memory request arbiter
`ifndef MRA_DEFINES_SVH
`define MRA_DEFINES_SVH
`define MRA_NUM_REQ     5
`define MRA_ADDR_W      24
`define MRA_SRC_W       3
`define MRA_TGT_W       2
`define MRA_TGT_SDRAM   2'h0
`define MRA_TGT_ASYNC   2'h1
`define MRA_TGT_CFG     2'h2
`define MRA_REGION_W    2
`define MRA_REGION_SDRAM 2'h0
`define MRA_REGION_ASYNC 2'h1
`define MRA_NONE        5'h00
`define MRA_ADDR_RST    24'h00_0000
`define MRA_SRC_RST     3'h0
`endif

//--- core/mra_pkg.sv
// Types shared by the memory request arbiter files
`include "mra_defines.svh"
package mra_pkg;
  typedef enum logic [1:0] {
    MRA_IDLE,
    MRA_REFRESH,
    MRA_SERVE
  } mra_state_t;

  typedef enum logic [`MRA_TGT_W-1:0] {
    MRA_TGT_SDRAM = `MRA_TGT_SDRAM,
    MRA_TGT_ASYNC = `MRA_TGT_ASYNC,
    MRA_TGT_CFG   = `MRA_TGT_CFG
  } mra_target_t;
endpackage : mra_pkg

//--- core/mra_sync.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
module mra_sync (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule : mra_sync

//--- tb/mra_requesters.sv
// Requester model: holds each request until its transfer completes
`timescale 1ns/100ps
module mra_requesters (
  input  logic       mclk_i,
  input  logic       rst_b_i,
  input  logic [4:0] want_i,
  input  logic [4:0] grant_i,
  input  logic       done_i,
  output logic [4:0] req_o
);
  logic [4:0] next_req;
  always_comb begin
    next_req = req_o | want_i;
    if (done_i) next_req = next_req & ~grant_i;
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) req_o <= 5'h00;
    else req_o <= next_req;
  end
endmodule : mra_requesters

//--- tb/mra_arbiter_assertions.sv
// Port checker for the memory request arbiter
`timescale 1ns/100ps
`include "mra_defines.svh"
module mra_arbiter_chk #(
  parameter int NUM_REQ = 5,
  parameter int ADDR_W  = 24
) (
  input logic                 mclk_i,
  input logic                 rst_b_i,
  input logic                 pll_rst_done_i,
  input logic [NUM_REQ-1:0]   req_i,
  input logic                 refresh_done_i,
  input logic                 svc_done_i,
  input logic [NUM_REQ-1:0]   grant_o,
  input logic                 fwd_valid_o,
  input logic [ADDR_W-1:0]    fwd_addr_o,
  input mra_pkg::mra_target_t fwd_target_o,
  input logic                 refresh_req_o,
  input logic                 mem_clk_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_served; !refresh_req_o && fwd_valid_o; endsequence
  property p_one; $onehot0(grant_o); endproperty
  a_one: assert property (p_one) else $error("grant not one-hot");
  property p_done; svc_done_i && fwd_valid_o |=> !fwd_valid_o && grant_o == '0;
  endproperty
  a_done: assert property (p_done) else $error("grant kept");
  property p_prio;
    $rose(|grant_o) |-> grant_o == ($past(req_i) & (~$past(req_i) + 1'b1));
  endproperty
  a_prio: assert property (p_prio) else $error("wrong winner");
  property p_hold; |grant_o && !svc_done_i |=> $stable(grant_o); endproperty
  a_hold: assert property (p_hold) else $error("grant moved");
  property p_tgt; |grant_o |-> fwd_target_o ==
    (fwd_addr_o[ADDR_W-1] ? 2'h2 : {1'b0, fwd_addr_o[ADDR_W-2]}); endproperty
  a_tgt: assert property (p_tgt) else $error("bad target");
  property p_ref; refresh_req_o && refresh_done_i |=> s_served; endproperty
  a_ref: assert property (p_ref) else $error("refresh order");
  property p_stop; !pll_rst_done_i && !mem_clk_o |=> !mem_clk_o; endproperty
  a_stop: assert property (p_stop) else $error("clock early");
  property p_run; $rose(mem_clk_o) |=> !mem_clk_o ##1 mem_clk_o; endproperty
  a_run: assert property (p_run) else $error("clock stalled");
endmodule : mra_arbiter_chk
bind mra_arbiter mra_arbiter_chk #(.NUM_REQ(NUM_REQ), .ADDR_W(ADDR_W)) i_chk (.*);

//--- tb/memif_request_arbiter_bench.sv
// Self-checking bench for the memory request arbiter
`timescale 1ns/100ps
module memif_request_arbiter_bench;
  logic                 mclk, rst_b, pll, due, rdone, sdone, fvalid, rreq, mclko;
  logic [4:0]           want, req, grant;
  logic [119:0]         addr;
  logic [23:0]          faddr;
  logic [2:0]           src;
  mra_pkg::mra_target_t tgt;
  int                   err_count = 0;
  int                   total_checks = 0;
  mra_requesters i_req (.mclk_i(mclk), .rst_b_i(rst_b), .want_i(want),
    .grant_i(grant), .done_i(sdone), .req_o(req));
  mra_arbiter i_dut (.mclk_i(mclk), .rst_b_i(rst_b), .pll_rst_done_i(pll),
    .req_i(req), .req_addr_i(addr), .refresh_due_i(due),
    .refresh_done_i(rdone), .svc_done_i(sdone), .grant_o(grant),
    .fwd_valid_o(fvalid), .fwd_addr_o(faddr), .fwd_target_o(tgt),
    .fwd_src_o(src), .refresh_req_o(rreq), .mem_clk_o(mclko));
  task automatic chk(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic ask(input logic [4:0] v);
    @(posedge mclk) want <= v;
    @(posedge mclk) want <= 5'h00;
  endtask : ask
  task automatic wt(input logic [2:0] s, input logic rf);
    int n;
    n = 0;
    #1;
    while (grant === 5'h00 && n < 40) @(posedge mclk) #1 n++;
    if (n == 40) begin err_count++; conclude; end
    chk(grant, 5'h01 << s);
    chk(src, s);
    chk(faddr, {s[1:0], 22'h00_0abc});
    chk(tgt, s[1] ? 2'h2 : {1'b0, s[0]});
    if (rf) begin
      chk({rreq, fvalid}, 2'h2);
      @(posedge mclk) begin due <= 1'b0; rdone <= 1'b1; end
      @(posedge mclk) rdone <= 1'b0;
      #1 chk({rreq, fvalid}, 2'h1);
    end
  endtask : wt
  task automatic fin;
    @(posedge mclk) sdone <= 1'b1;
    @(posedge mclk) sdone <= 1'b0;
    #1 chk({grant, fvalid}, 6'h00);
  endtask : fin
  task automatic t_clock;
    int n;
    n = 0;
    @(posedge mclk) pll <= 1'b1;
    repeat (3) @(posedge mclk) #1 chk(mclko, 1'b0);
    while (mclko !== 1'b1 && n < 12) @(posedge mclk) #1 n++;
    if (n == 12) begin err_count++; conclude; end
    @(posedge mclk) #1 chk(mclko, 1'b0);
    @(posedge mclk) #1 chk(mclko, 1'b1);
  endtask : t_clock
  task automatic t_prio;
    ask(5'h1f);
    for (int s = 0; s < 5; s++) begin
      wt(s[2:0], 1'b0);
      fin;
    end
  endtask : t_prio
  task automatic t_hold;
    ask(5'h10);
    wt(3'h4, 1'b0);
    ask(5'h01);
    repeat (3) @(posedge mclk);
    #1 chk(grant, 5'h10);
    fin;
    wt(3'h0, 1'b0);
    fin;
  endtask : t_hold
  task automatic t_refresh;
    @(posedge mclk) due <= 1'b1;
    ask(5'h02);
    wt(3'h1, 1'b1);
    fin;
  endtask : t_refresh
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {rst_b, pll, due, rdone, sdone, want} = '0;
    for (int i = 0; i < 5; i++) addr[i*24 +: 24] = {i[1:0], 22'h00_0abc};
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    t_clock;
    t_prio;
    t_hold;
    t_refresh;
    conclude;
  end
endmodule : memif_request_arbiter_bench
